// file: verilog/i2c_ctrl_pkg.sv
`default_nettype none
package i2c_ctrl_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_BUS_IF_CONTROL    = 10'h0F9;
  localparam logic [9:0] IDX_BUS_CLOCK_CONTROL = 10'h0FA;
  localparam logic [9:0] IDX_IRQ_REQUEST_TWO   = 10'h0FD;
  localparam logic [9:0] IDX_IRQ_CONTROL_TWO   = 10'h0FF;
  localparam logic [9:0] IDX_XFER_DATA         = 10'h100;
  localparam logic [9:0] IDX_OWN_ADDRESS       = 10'h101;
  localparam logic [9:0] IDX_XFER_STATUS       = 10'h102;

  // Field positions of the interface control register.
  localparam int BIT_COUNT_LSB   = 0;
  localparam int IF_ENABLE_BIT   = 3;
  localparam int FREE_FORMAT_BIT = 4;
  localparam int WIDE_ADDR_BIT   = 5;
  localparam int ROUTE_LOW_BIT   = 6;
  localparam int ROUTE_HIGH_BIT  = 7;

  // Field positions of the clock control register.
  localparam int DIVIDER_LSB     = 0;
  localparam int FAST_MODE_BIT   = 5;
  localparam int ACK_LEVEL_BIT   = 6;
  localparam int ACK_CLOCK_BIT   = 7;

  // Interrupt bit position in the request and control registers.
  localparam int IRQ_BUS_BIT     = 5;

  // Transfer data register and status register layout.
  localparam int XFER_STOP_BIT   = 8;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_HOLD_BIT   = 1;
  localparam int STAT_MATCH_BIT  = 2;
  localparam int STAT_ACK_BIT    = 3;
  localparam int STAT_SCL_BIT    = 4;
  localparam int STAT_RX_LSB     = 8;

  // Reset values.
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CLKC_RESET     = 8'h00;
  localparam logic [9:0] OWN_ADDR_RESET = 10'h000;

  // Address patterns and divider limits.
  localparam logic [4:0] WIDE_ADDR_PREFIX = 5'h1E;
  localparam logic [4:0] DIVIDER_MIN      = 5'h03;
  localparam logic [4:0] HS400_DIVIDER    = 5'h05;
  localparam logic [3:0] BYTE_BITS        = 4'h8;

  // Timing in nanoseconds and the cycle counts derived from it.
  localparam logic [15:0] CLK_PERIOD_NS        = 16'h0028;
  localparam logic [15:0] STD_HALF_NS_PER_STEP = 16'h03E8;
  localparam logic [15:0] HS_HALF_NS_PER_STEP  = 16'h01F4;
  localparam logic [15:0] HS400_LOW_NS         = 16'h05DC;
  localparam logic [15:0] HS400_HIGH_NS        = 16'h03E8;
  localparam logic [15:0] STD_CYC_PER_STEP =
    STD_HALF_NS_PER_STEP / CLK_PERIOD_NS;
  localparam logic [15:0] HS400_LOW_CYC  = HS400_LOW_NS / CLK_PERIOD_NS;
  localparam logic [15:0] HS400_HIGH_CYC = HS400_HIGH_NS / CLK_PERIOD_NS;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_START   = 3'b001,
    ST_BITS    = 3'b010,
    ST_ACK     = 3'b011,
    ST_HOLD    = 3'b100,
    ST_STOP    = 3'b101,
    ST_STOP_HI = 3'b110
  } xfer_state_e;

endpackage
`default_nettype wire

// file: verilog/scl_gen_if.sv
`timescale 1ns/1ns
`default_nettype none
interface scl_gen_if;
  logic       run;
  logic       park_high;
  logic       end_high;
  logic       fast_mode;
  logic [4:0] divider;
  logic       scl_level;
  logic       rise_tick;
  logic       fall_tick;

  modport gen (input run, park_high, end_high, fast_mode, divider,
               output scl_level, rise_tick, fall_tick);
  modport ctl (output run, park_high, end_high, fast_mode, divider,
               input scl_level, rise_tick, fall_tick);
endinterface
`default_nettype wire

// file: verilog/scl_gen.sv
`timescale 1ns/1ns
`default_nettype none
module scl_gen
  import i2c_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  scl_gen_if.gen    g
);

  logic [15:0] acc_q;
  logic        phase_q;
  logic [15:0] cyc_q;
  logic [4:0]  div_eff;
  logic [15:0] target;
  logic [15:0] step;
  logic        tick;
  logic        hs400;

  // Values below the legal minimum are clamped so a bad setting cannot
  // make the phase counter fire on every cycle.
  assign div_eff = (g.divider < DIVIDER_MIN) ? DIVIDER_MIN : g.divider; // R9
  assign hs400   = g.fast_mode && (g.divider == HS400_DIVIDER);

  // Half-period length in ns for the phase now running.
  always_comb begin
    if (hs400) begin
      target = phase_q ? HS400_HIGH_NS : HS400_LOW_NS; // R11
    end else if (g.fast_mode) begin
      target = 16'(16'(div_eff) * HS_HALF_NS_PER_STEP); // R8
    end else begin
      target = 16'(16'(div_eff) * STD_HALF_NS_PER_STEP); // R12
    end
  end

  assign step = acc_q + CLK_PERIOD_NS;
  assign tick = g.run && (step >= target);

  // The remainder is carried over so odd half-periods average out exactly.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 16'h0000;
    end else if (ce) begin
      if (!g.run) begin
        acc_q <= 16'h0000;
      end else if (tick) begin
        acc_q <= step - target; // R8
      end else begin
        acc_q <= step;
      end
    end
  end

  // Line phase; a stop keeps the line high at the end of its high phase.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 1'b1;
    end else if (ce) begin
      if (!g.run) begin
        if (g.park_high) begin
          phase_q <= 1'b1;
        end
      end else if (tick && !(phase_q && g.end_high)) begin
        phase_q <= ~phase_q; // R13
      end
    end
  end

  assign g.scl_level = phase_q;
  assign g.rise_tick = tick && !phase_q;
  assign g.fall_tick = tick && phase_q;

  //////////////////////////////////////////////////////////////////////////
  // Phase-length checks.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= 16'h0000;
    end else if (ce) begin
      cyc_q <= (!g.run || tick) ? 16'h0000 : cyc_q + 16'h0001;
    end
  end

  property p_hs400_high;
    @(posedge clk) disable iff (!resetn)
      (ce && hs400 && g.fall_tick) |-> (cyc_q + 16'h0001 == HS400_HIGH_CYC);
  endproperty
  a_hs400_high: assert property (p_hs400_high) // R13
    else $error("high phase at 400 kHz is not two fifths");

  property p_hs400_low;
    @(posedge clk) disable iff (!resetn)
      (ce && hs400 && g.rise_tick) |->
        (cyc_q + 16'h0001 == HS400_LOW_CYC) ||
        (cyc_q == HS400_LOW_CYC);
  endproperty
  a_hs400_low: assert property (p_hs400_low) // R11
    else $error("low phase at 400 kHz is not three fifths");

  property p_std_half;
    @(posedge clk) disable iff (!resetn)
      (ce && !g.fast_mode && tick && g.divider >= DIVIDER_MIN) |->
        (cyc_q + 16'h0001 == 16'(16'(g.divider) * STD_CYC_PER_STEP));
  endproperty
  a_std_half: assert property (p_std_half) // R14
    else $error("standard mode half period wrong or unequal");

endmodule
`default_nettype wire

// file: verilog/i2c_ctrl.sv
// Behaviour
// R1: Three-bit count code 0 sends eight bits, each higher code one fewer.
// R2: The interface joins bus activity only while its enable bit is set.
// R3: Format bit 0 compares incoming addresses; 1 is free data format.
// R4: Address width bit selects 7-bit or 10-bit address compare.
// R5: Bits 7 and 6 route the interface to none, first, second or both pairs.
// R6: Software sets each used pin's port direction bit to 1 first.
// R7: Software clears bit 2 of port 3 before using either pin pair.
// R8: Clock is 500/N kHz standard, 1000/N kHz high speed at 4 MHz base.
// R9: Software never programs divider values 0 to 2.
// R10: Divider 3 and 4 are not used in standard mode.
// R11: Divider 5 gives 100 kHz standard and 400 kHz high speed.
// R12: Mode bit picks standard or high-speed clock timing.
// R13: At 400 kHz high speed the clock low and high split 3:2.
// R14: Every other clock setting has equal low and high periods.
// R15: Acknowledge bit 0 pulls data low in the slot; 1 leaves it high.
// R16: Acknowledge clock bit adds one extra clock pulse after the data bits.
// R17: The interrupt request bit sets on an interface event, resets to 0.
// R18: Software may only clear the request bit; writing 1 changes nothing.
// R19: The interrupt reaches the processor only while its enable bit is set.
// R20: Both configuration registers reset to zero.
// R21: The request sets when each unit, with any acknowledge slot, completes.
`timescale 1ns/1ns
`default_nettype none
module i2c_ctrl
  import i2c_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        first_clock_pin_in,
  output logic             first_clock_pin_out,
  output logic             first_clock_pin_oe,
  input  wire logic        first_data_pin_in,
  output logic             first_data_pin_out,
  output logic             first_data_pin_oe,
  input  wire logic        second_clock_pin_in,
  output logic             second_clock_pin_out,
  output logic             second_clock_pin_oe,
  input  wire logic        second_data_pin_in,
  output logic             second_data_pin_out,
  output logic             second_data_pin_oe,
  output logic             bus_irq
);

  scl_gen_if   sg ();

  logic [7:0]  bus_if_control_q;
  logic [7:0]  bus_clock_control_q;
  logic        bus_irq_request_q;
  logic        bus_irq_enable_q;
  logic [9:0]  own_addr_q;
  logic        wr_pend_q;
  logic [9:0]  wr_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata_d;
  logic        accept;
  xfer_state_e state_q;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;
  logic [7:0]  rx_data_q;
  logic [3:0]  bits_left_q;
  logic [3:0]  bit_rises_q;
  logic        go_q;
  logic        stop_after_q;
  logic        first_unit_q;
  logic        addr_match_q;
  logic        ack_seen_q;
  logic        if_enable;
  logic        route_low;
  logic        route_high;
  logic        ack_level;
  logic        ack_clock;
  logic [3:0]  nbits;
  logic        load_bits;
  logic        unit_done;
  logic        xfer_wr;
  logic        sda_low;
  logic        sda_in;
  logic        scl_in;
  logic        match_d;

  //////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  // Zero wait states; a frozen block stalls the bus instead of dropping data.
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign accept    = hsel && hready && htrans[1] && (hsize == 3'b010);

  // Address phase is captured; writes complete in the following data phase.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 10'h000;
    end else if (ce) begin
      wr_pend_q <= accept && hwrite;
      wr_idx_q  <= haddr[11:2];
    end
  end

  // Read data is latched at the address phase; unmapped indices read zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[11:2])
      IDX_BUS_IF_CONTROL:    rdata_d[7:0] = bus_if_control_q;
      IDX_BUS_CLOCK_CONTROL: rdata_d[7:0] = bus_clock_control_q;
      IDX_IRQ_REQUEST_TWO:   rdata_d[IRQ_BUS_BIT] = bus_irq_request_q;
      IDX_IRQ_CONTROL_TWO:   rdata_d[IRQ_BUS_BIT] = bus_irq_enable_q;
      IDX_OWN_ADDRESS:       rdata_d[9:0] = own_addr_q;
      IDX_XFER_STATUS: begin
        rdata_d[STAT_BUSY_BIT]  = (state_q != ST_IDLE);
        rdata_d[STAT_HOLD_BIT]  = (state_q == ST_HOLD);
        rdata_d[STAT_MATCH_BIT] = addr_match_q;
        rdata_d[STAT_ACK_BIT]   = ack_seen_q;
        rdata_d[STAT_SCL_BIT]   = scl_in;
        rdata_d[STAT_RX_LSB +: 8] = rx_data_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && accept && !hwrite) begin
      hrdata_q <= rdata_d;
    end
  end

  // Configuration registers all start at zero: disabled, unrouted, standard.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_if_control_q    <= CTRL_RESET; // R20
      bus_clock_control_q <= CLKC_RESET; // R20
      bus_irq_enable_q    <= 1'b0;
      own_addr_q          <= OWN_ADDR_RESET;
    end else if (ce && wr_pend_q) begin
      case (wr_idx_q)
        IDX_BUS_IF_CONTROL:    bus_if_control_q    <= hwdata[7:0];
        IDX_BUS_CLOCK_CONTROL: bus_clock_control_q <= hwdata[7:0];
        IDX_IRQ_CONTROL_TWO:   bus_irq_enable_q    <= hwdata[IRQ_BUS_BIT];
        IDX_OWN_ADDRESS:       own_addr_q          <= hwdata[9:0];
        default: ;
      endcase
    end
  end

  // A completed unit wins over a clearing write in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_irq_request_q <= 1'b0;
    end else if (ce) begin
      if (unit_done) begin
        bus_irq_request_q <= 1'b1; // R17
      end else if (wr_pend_q && wr_idx_q == IDX_IRQ_REQUEST_TWO &&
                   !hwdata[IRQ_BUS_BIT]) begin
        bus_irq_request_q <= 1'b0; // R18
      end
    end
  end

  assign bus_irq = bus_irq_request_q && bus_irq_enable_q; // R19

  //////////////////////////////////////////////////////////////////////////
  // Field decode and clock generator control.

  assign if_enable  = bus_if_control_q[IF_ENABLE_BIT];
  assign route_low  = bus_if_control_q[ROUTE_LOW_BIT];
  assign route_high = bus_if_control_q[ROUTE_HIGH_BIT];
  assign ack_level  = bus_clock_control_q[ACK_LEVEL_BIT];
  assign ack_clock  = bus_clock_control_q[ACK_CLOCK_BIT];
  assign nbits = BYTE_BITS - {1'b0, bus_if_control_q[BIT_COUNT_LSB +: 3]}; // R1

  assign sg.fast_mode = bus_clock_control_q[FAST_MODE_BIT]; // R12
  assign sg.divider   = bus_clock_control_q[DIVIDER_LSB +: 5]; // R8
  assign sg.run       = if_enable && (state_q != ST_IDLE) &&
                        (state_q != ST_HOLD); // R2
  assign sg.park_high = (state_q == ST_IDLE);
  assign sg.end_high  = (state_q == ST_STOP_HI);

  scl_gen u_scl_gen (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .g      (sg)
  );

  //////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  assign load_bits = sg.fall_tick && (state_q == ST_START) ||
                     go_q && (state_q == ST_HOLD);
  assign unit_done = if_enable && sg.fall_tick &&
                     ((state_q == ST_BITS && bits_left_q == 4'h0 &&
                       !ack_clock) || state_q == ST_ACK); // R21
  assign xfer_wr   = wr_pend_q && wr_idx_q == IDX_XFER_DATA && if_enable &&
                     !go_q && (state_q == ST_IDLE || state_q == ST_HOLD);

  // A disabled interface drops back to idle and releases the lines.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      if (!if_enable) begin
        state_q <= ST_IDLE; // R2
      end else begin
        case (state_q)
          ST_IDLE:    if (go_q) state_q <= ST_START;
          ST_START:   if (sg.fall_tick) state_q <= ST_BITS;
          ST_BITS: begin
            if (sg.fall_tick && bits_left_q == 4'h0) begin
              if (ack_clock) begin
                state_q <= ST_ACK; // R16
              end else begin
                state_q <= stop_after_q ? ST_STOP : ST_HOLD;
              end
            end
          end
          ST_ACK:     if (sg.fall_tick)
                        state_q <= stop_after_q ? ST_STOP : ST_HOLD;
          ST_HOLD:    if (go_q) state_q <= ST_BITS;
          ST_STOP:    if (sg.rise_tick) state_q <= ST_STOP_HI;
          ST_STOP_HI: if (sg.fall_tick) state_q <= ST_IDLE;
          default:    state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // A data write queues one unit; it is ignored while one is in flight.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      go_q         <= 1'b0;
      stop_after_q <= 1'b0;
    end else if (ce) begin
      if (xfer_wr) begin
        go_q         <= 1'b1;
        stop_after_q <= hwdata[XFER_STOP_BIT];
      end else if (!if_enable || state_q == ST_IDLE && go_q ||
                   state_q == ST_HOLD && go_q) begin
        go_q <= 1'b0;
      end
    end
  end

  // Transmit shifter: the next bit is placed while the clock is low.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_q <= 8'hFF;
    end else if (ce) begin
      if (xfer_wr) begin
        tx_q <= hwdata[7:0];
      end else if (state_q == ST_BITS && sg.fall_tick &&
                   bits_left_q != 4'h0) begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // Receive side samples the line on each rising clock.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_q        <= 8'h00;
      bits_left_q <= 4'h0;
      bit_rises_q <= 4'h0;
      ack_seen_q  <= 1'b0;
    end else if (ce) begin
      if (load_bits) begin
        rx_q        <= 8'h00;
        bits_left_q <= nbits; // R1
        bit_rises_q <= 4'h0;
      end else if (state_q == ST_BITS && sg.rise_tick &&
                   bits_left_q != 4'h0) begin
        rx_q        <= {rx_q[6:0], sda_in};
        bits_left_q <= bits_left_q - 4'h1;
        bit_rises_q <= bit_rises_q + 4'h1;
      end else if (state_q == ST_ACK && sg.rise_tick) begin
        ack_seen_q <= !sda_in;
      end
    end
  end

  // Address compare on the first unit after a start, in addressing mode.
  always_comb begin
    if (bus_if_control_q[WIDE_ADDR_BIT]) begin
      match_d = (rx_q[7:3] == WIDE_ADDR_PREFIX) &&
                (rx_q[2:1] == own_addr_q[9:8]); // R4
    end else begin
      match_d = (rx_q[7:1] == own_addr_q[6:0]); // R4
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_q    <= 8'h00;
      first_unit_q <= 1'b0;
      addr_match_q <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_IDLE && go_q) begin
        first_unit_q <= 1'b1;
        addr_match_q <= 1'b0;
      end else if (unit_done) begin
        rx_data_q    <= rx_q;
        first_unit_q <= 1'b0;
        if (first_unit_q && !bus_if_control_q[FREE_FORMAT_BIT]) begin
          addr_match_q <= match_d; // R3
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins. Open drain: the output is always low and the enable pulls.

  // Start and stop hold data low; the slot drives the programmed level.
  always_comb begin
    case (state_q)
      ST_START, ST_STOP, ST_STOP_HI: sda_low = 1'b1;
      ST_BITS: sda_low = !tx_q[7];
      ST_ACK:  sda_low = !ack_level; // R15
      default: sda_low = 1'b0;
    endcase
  end

  // Pins are taken to be already handed to the interface by software.
  assign sda_in = (!route_low || first_data_pin_in) &&
                  (!route_high || second_data_pin_in); // R6
  assign scl_in = (!route_low || first_clock_pin_in) &&
                  (!route_high || second_clock_pin_in); // R7

  assign first_clock_pin_out  = 1'b0;
  assign first_data_pin_out   = 1'b0;
  assign second_clock_pin_out = 1'b0;
  assign second_data_pin_out  = 1'b0;
  assign first_clock_pin_oe   = if_enable && route_low && !sg.scl_level; // R5
  assign first_data_pin_oe    = if_enable && route_low && sda_low; // R5
  assign second_clock_pin_oe  = if_enable && route_high && !sg.scl_level;
  assign second_data_pin_oe   = if_enable && route_high && sda_low; // R5

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_unit_bits;
    @(posedge clk) disable iff (!resetn)
      (ce && unit_done) |-> (bit_rises_q == nbits);
  endproperty
  a_unit_bits: assert property (p_unit_bits) // R1
    else $error("unit length differs from programmed bit count");

  property p_disabled_idle;
    @(posedge clk) disable iff (!resetn)
      (ce && !if_enable) |=> (state_q == ST_IDLE) && !sg.run;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) // R2
    else $error("disabled interface still active");

  property p_route_none;
    @(posedge clk) disable iff (!resetn)
      !route_low && !route_high |->
        !(first_data_pin_oe || first_clock_pin_oe ||
          second_data_pin_oe || second_clock_pin_oe);
  endproperty
  a_route_none: assert property (p_route_none) // R5
    else $error("pin driven while unrouted");

  property p_ack_level;
    @(posedge clk) disable iff (!resetn)
      (state_q == ST_ACK && route_low && if_enable) |->
        (first_data_pin_oe == !ack_level);
  endproperty
  a_ack_level: assert property (p_ack_level) // R15
    else $error("acknowledge slot drives wrong level");

  property p_no_ack_clock;
    @(posedge clk) disable iff (!resetn)
      (ce && if_enable && state_q == ST_BITS && sg.fall_tick &&
       bits_left_q == 4'h0 && !ack_clock) |=> (state_q != ST_ACK);
  endproperty
  a_no_ack_clock: assert property (p_no_ack_clock) // R16
    else $error("acknowledge clock produced while off");

  property p_irq_set;
    @(posedge clk) disable iff (!resetn)
      (ce && unit_done) |=> bus_irq_request_q ##1
        (bus_irq_request_q ||
         ($past(wr_pend_q) && $past(wr_idx_q) == IDX_IRQ_REQUEST_TWO));
  endproperty
  a_irq_set: assert property (p_irq_set) // R21
    else $error("request not raised after a completed unit");

  property p_irq_write_one;
    @(posedge clk) disable iff (!resetn)
      (ce && !bus_irq_request_q && !unit_done) |=> !bus_irq_request_q;
  endproperty
  a_irq_write_one: assert property (p_irq_write_one) // R18
    else $error("request set without an event");

  property p_irq_gate;
    @(posedge clk) disable iff (!resetn)
      $fell(bus_irq_enable_q) |-> !bus_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R19
    else $error("interrupt forwarded while disabled");

  property p_reset_zero;
    @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> (bus_if_control_q == CTRL_RESET) &&
                        (bus_clock_control_q == CLKC_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R20
    else $error("configuration not zero after reset");

endmodule
`default_nettype wire

// file: bench/i2c_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far side of the bus: pull-ups on all four lines, wired-and with the device.
module i2c_bus_model (
  input  wire logic [3:0] dev_oe,
  output logic [3:0]      line
);
  // A released line floats high, so no stale value is ever shown.
  assign line = ~dev_oe;
endmodule
`default_nettype wire

// file: bench/multi_master_i2c_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module multi_master_i2c_control_tb;
  import i2c_ctrl_pkg::*;
  logic clk = 0, resetn = 0, hwrite = 0, hready, hresp, bus_irq;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, r, v;
  logic [3:0] oe, line;
  int errors = 0, n_compared = 0, cyc = 0, n, lo, hi;
  //////////////////////////////////////////////////////////////////////////
  // Clock; the cycle ceiling cuts a hang short.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  i2c_ctrl i_i2c_ctrl (.clk(clk), .resetn(resetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .first_clock_pin_in(line[0]), .first_clock_pin_out(),
    .first_clock_pin_oe(oe[0]), .first_data_pin_in(line[1]),
    .first_data_pin_out(), .first_data_pin_oe(oe[1]),
    .second_clock_pin_in(line[2]), .second_clock_pin_out(),
    .second_clock_pin_oe(oe[2]), .second_data_pin_in(line[3]),
    .second_data_pin_out(), .second_data_pin_oe(oe[3]), .bus_irq(bus_irq));
  i2c_bus_model i_i2c_bus_model (.dev_oe(oe), .line(line));
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // A unit of count code c keeps the top 8-c bits sent, in arrival order.
  function automatic logic [31:0] exp_rx(input logic [7:0] d,
                                         input logic [2:0] c);
    return {24'h0, d >> c};
  endfunction
  // One single AHB transfer; waits for hready in both phases.
  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge clk);
    haddr <= {i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Counts cycles while the first clock pin's enable holds one level.
  task automatic span(input logic lvl, output int c);
    c = 0;
    while (oe[0] === lvl && c < 3000) begin
      @(posedge clk);
      c++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, random read-back, then timed transfers.
  initial begin
    void'($urandom(32'hfeb2));
    repeat (3) @(posedge clk);
    resetn <= 1;
    bus(0, IDX_BUS_IF_CONTROL, 0); chk(r, 0);
    bus(0, IDX_BUS_CLOCK_CONTROL, 0); chk(r, 0);
    bus(0, IDX_IRQ_CONTROL_TWO, 0); chk(r, 0);
    bus(0, 10'h000, 0); chk(r, 0);
    chk(hresp, 0);
    for (int k = 0; k < 6; k++) begin
      v = $urandom;
      v[11] = 1'b1;
      bus(1, IDX_BUS_IF_CONTROL, {24'h0, v[7:4], 1'b0, v[2:0]});
      bus(0, IDX_BUS_IF_CONTROL, 0); chk(r, {24'h0, v[7:4], 1'b0, v[2:0]});
      bus(1, IDX_BUS_CLOCK_CONTROL, {24'h0, v[15:8]});
      bus(0, IDX_BUS_CLOCK_CONTROL, 0); chk(r, {24'h0, v[15:8]});
    end
    for (int m = 0; m < 2; m++) begin
      bus(1, IDX_BUS_CLOCK_CONTROL, m ? 32'hA5 : 32'h05);
      bus(1, IDX_BUS_IF_CONTROL, 32'h4E);
      bus(1, IDX_IRQ_CONTROL_TWO, 32'h20);
      bus(1, IDX_XFER_DATA, 32'h1A5);
      span(0, n);
      span(1, lo);
      span(0, hi);
      chk((m && lo == 38) ? 37 : lo, m ? 37 : 125);
      chk(hi, m ? 25 : 125);
      n = 0;
      while (bus_irq !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      chk(bus_irq, 1);
      bus(1, IDX_IRQ_CONTROL_TWO, 0);
      // The enable lands at the data-phase edge; look once it has settled.
      @(negedge clk);
      chk(bus_irq, 0);
      bus(1, IDX_IRQ_REQUEST_TWO, 32'h20);
      bus(0, IDX_IRQ_REQUEST_TWO, 0); chk(r[5], 1);
      bus(1, IDX_IRQ_REQUEST_TWO, 0);
      bus(0, IDX_IRQ_REQUEST_TWO, 0); chk(r[5], 0);
      n = 0;
      do begin
        bus(0, IDX_XFER_STATUS, 0);
        n++;
      end while (r[0] !== 1'b0 && n < 2000);
      chk(r[0], 0);
      chk(r[3], m);
      chk(r[15:8], exp_rx(8'hA5, 3'd6));
    end
    summarize();
  end
endmodule
`default_nettype wire
